// file: design/cdv_field.v
// Purpose: One lockable, host-writable register field with trim reset.
// Assumes: Same clock as the register bus; synchronous active-low reset.
// Notes:   Reset value comes from a port sampled at the clocked reset.
`timescale 1ns/1ps
module cdv_field #(
  parameter W = 6
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] rst_val,
  input  wire         wr_en,
  input  wire         lock,
  input  wire [W-1:0] wr_val,
  output reg  [W-1:0] val_q
);

  reg [W-1:0] val_d;

  always @* begin
    val_d = val_q;
    if (wr_en && !lock) begin
      val_d = wr_val;
    end
  end

  // Synchronous reset, so loading a trim level here is legal
  always @(posedge clk) begin
    if (!rst_n) begin
      val_q <= rst_val;
    end else begin
      val_q <= val_d;
    end
  end

endmodule // cdv_field

// file: design/cdv_regs.v
// Purpose: Dead-battery charge and battery voltage configuration registers.
// Assumes: Host accesses arrive as a same-clock strobe from the bus slave;
//          lock and trim levels come from the same clock domain.
// Notes:   Decoded settings go to the analog charger core.
// Contract
// R1 - Both registers read and write by host, gated by the charger write lock.
// R2 - Bits 7:6 select dead phase timer 5/10/20/40 sec, reset 00.
// R3 - Bits 5:0 set dead current 1 mA per code, reset 04h.
// R4 - Host keeps dead current code no greater than pre-charge code.
// R5 - Dead current bits 2 and 4 reset from nonvolatile trim.
// R6 - Second register bit 6 picks recharge drop 140 or 240 mV, reset 0.
// R7 - Recharge select reset comes from one nonvolatile trim bit.
// R8 - Voltage code 00h is 3.60 V plus 20 mV per step, reset 1Eh.
// R9 - Voltage codes 32h to 3Fh all give 4.60 V.
// R10 - Voltage code reset is loadable from trim, factory 4.20 V.
// R11 - Pre-charge code bounding dead current resets to 08h, 8 mA.
// R12 - Locked writes change nothing; reads still return stored values.
// R13 - Reserved bit 7 stores host data, resets 0, no effect.
`timescale 1ns/1ps
`include "cdv_regs_map.vh"
module cdv_regs (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_q,
  output reg         reg_hit_q,
  input  wire        charger_write_lock,
  input  wire        trim_dead_b2,
  input  wire        trim_dead_b4,
  input  wire        trim_restart,
  input  wire [5:0]  trim_vreg,
  input  wire [5:0]  precharge_current_sel,
  output reg  [1:0]  dead_phase_timer_sel_q,
  output reg  [5:0]  dead_phase_timer_sec_q,
  output reg  [5:0]  dead_phase_current_sel_q,
  output reg  [5:0]  dead_phase_current_ma_q,
  output reg         dead_current_over_precharge_q,
  output reg         recharge_sel_q,
  output reg  [7:0]  recharge_drop_mv_q,
  output reg  [5:0]  vreg_code_q,
  output reg  [12:0] vreg_mv_q
);

  // Field widths follow the bit ranges of the map
  localparam TMR_W  = `CDV_DEAD_TMR_HI - `CDV_DEAD_TMR_LO + 1;
  localparam CUR_W  = `CDV_DEAD_CUR_HI - `CDV_DEAD_CUR_LO + 1;
  localparam VREG_W = `CDV_VREG_HI - `CDV_VREG_LO + 1;
  localparam [CUR_W-1:0] DEAD_CUR_RST = `CDV_RST_DEAD_CUR;

  // Dead phase timer select codes
  localparam [TMR_W-1:0] TSEL_5S  = 2'h0;
  localparam [TMR_W-1:0] TSEL_10S = 2'h1;
  localparam [TMR_W-1:0] TSEL_20S = 2'h2;
  localparam [TMR_W-1:0] TSEL_40S = 2'h3;

  wire              hit_dead;
  wire              hit_vbat;
  wire              hit_any;
  wire              acc_any;
  wire              wr_dead;
  wire              wr_vbat;

  wire [TMR_W-1:0]  tmr_q;
  wire [CUR_W-1:0]  cur_q;
  wire [0:0]        reserved_bit_q;
  wire [0:0]        rst_q;
  wire [VREG_W-1:0] vreg_q;
  wire [CUR_W-1:0]  cur_rst;

  assign hit_dead = (reg_addr == `CDV_ADDR_DEAD_CFG);
  assign hit_vbat = (reg_addr == `CDV_ADDR_VBAT_CFG);
  assign hit_any  = hit_dead | hit_vbat;
  assign acc_any  = (reg_rd | reg_wr) & hit_any;
  assign wr_dead  = reg_wr & hit_dead;                    // [R1]
  assign wr_vbat  = reg_wr & hit_vbat;                    // [R1]

  // Trim only owns bits 2 and 4 of the dead current default;
  // the other bits keep their fixed reset code
  genvar g;
  generate
    for (g = 0; g < CUR_W; g = g + 1) begin : g_cur_rst
      if (g == `CDV_DEAD_TRIM_B2) begin : g_b2
        assign cur_rst[g] = trim_dead_b2;                 // [R5]
      end else if (g == `CDV_DEAD_TRIM_B4) begin : g_b4
        assign cur_rst[g] = trim_dead_b4;                 // [R5]
      end else begin : g_fix
        assign cur_rst[g] = DEAD_CUR_RST[g];              // [R3]
      end
    end
  endgenerate

  cdv_field #(.W(2)) u_tmr (
    .clk     (clk),
    .rst_n   (rst_n),
    .rst_val (`CDV_RST_DEAD_TMR),                        // [R2]
    .wr_en   (wr_dead),                                  // [R1]
    .lock    (charger_write_lock),                       // [R12]
    .wr_val  (reg_wdata[`CDV_DEAD_TMR_HI:`CDV_DEAD_TMR_LO]),
    .val_q   (tmr_q)
  );

  cdv_field #(.W(6)) u_cur (
    .clk     (clk),
    .rst_n   (rst_n),
    .rst_val (cur_rst),
    .wr_en   (wr_dead),                                  // [R1]
    .lock    (charger_write_lock),                       // [R12]
    .wr_val  (reg_wdata[`CDV_DEAD_CUR_HI:`CDV_DEAD_CUR_LO]),
    .val_q   (cur_q)
  );

  cdv_field #(.W(1)) u_reserved_bit (
    .clk     (clk),
    .rst_n   (rst_n),
    .rst_val (`CDV_RST_RESERVED_BIT),                            // [R13]
    .wr_en   (wr_vbat),
    .lock    (charger_write_lock),                       // [R12]
    .wr_val  (reg_wdata[`CDV_RESERVED_BIT_BIT]),
    .val_q   (reserved_bit_q)
  );

  cdv_field #(.W(1)) u_restart (
    .clk     (clk),
    .rst_n   (rst_n),
    .rst_val (trim_restart),                             // [R6] [R7]
    .wr_en   (wr_vbat),                                  // [R1]
    .lock    (charger_write_lock),                       // [R12]
    .wr_val  (reg_wdata[`CDV_RESTART_BIT]),
    .val_q   (rst_q)
  );

  cdv_field #(.W(6)) u_vreg (
    .clk     (clk),
    .rst_n   (rst_n),
    .rst_val (trim_vreg),                                // [R8] [R10]
    .wr_en   (wr_vbat),                                  // [R1]
    .lock    (charger_write_lock),                       // [R12]
    .wr_val  (reg_wdata[`CDV_VREG_HI:`CDV_VREG_LO]),
    .val_q   (vreg_q)
  );

  // Next values of the registered outputs
  reg [7:0]         rdata_d;
  reg [7:0]         reg_rdata_d;
  reg               reg_hit_d;
  reg [TMR_W-1:0]   timer_sel_d;
  reg [5:0]         timer_sec_d;
  reg [CUR_W-1:0]   cur_sel_d;
  reg [5:0]         cur_ma_d;
  reg               over_d;
  reg               rchg_sel_d;
  reg [7:0]         drop_mv_d;
  reg [VREG_W-1:0]  vreg_code_d;
  reg [VREG_W-1:0]  vsat;
  reg [12:0]        vstep;
  reg [12:0]        vreg_mv_d;

  // Unmapped addresses read as zero
  always @* begin
    rdata_d = `CDV_RDATA_UNMAPPED;
    if (hit_dead) begin
      rdata_d = {tmr_q, cur_q};                           // [R1] [R12]
    end else if (hit_vbat) begin
      rdata_d = {reserved_bit_q, rst_q, vreg_q};                  // [R1] [R13]
    end
  end

  // Read data holds until the next read; writes leave it alone
  always @* begin
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      reg_rdata_d = rdata_d;                              // [R12]
    end
    reg_hit_d = acc_any;                                  // [R1]
  end

  always @* begin
    timer_sel_d = tmr_q;
    case (tmr_q)
      TSEL_5S:  timer_sec_d = `CDV_TMR_5S;                // [R2]
      TSEL_10S: timer_sec_d = `CDV_TMR_10S;               // [R2]
      TSEL_20S: timer_sec_d = `CDV_TMR_20S;               // [R2]
      TSEL_40S: timer_sec_d = `CDV_TMR_40S;               // [R2]
      default:  timer_sec_d = `CDV_TMR_5S;
    endcase
  end

  // One code step is one milliamp, so the code passes through
  always @* begin
    cur_sel_d = cur_q;
    cur_ma_d  = cur_q;                                    // [R3]
  end

  // Host is expected to keep this low; flagged, not enforced
  always @* begin
    over_d = (cur_q > precharge_current_sel);             // [R4] [R11]
  end

  // Reserved bit 7 is stored and read back but feeds nothing here
  always @* begin
    rchg_sel_d = rst_q[0];
    if (rst_q[0]) begin
      drop_mv_d = `CDV_RESTART_HI_MV;                     // [R6]
    end else begin
      drop_mv_d = `CDV_RESTART_LO_MV;                     // [R6]
    end
  end

  // Codes past the ceiling pin at 4.60 V rather than wrapping
  always @* begin
    vreg_code_d = vreg_q;
    if (vreg_q > `CDV_VREG_MAX_CODE) begin
      vsat = `CDV_VREG_MAX_CODE;                          // [R9]
    end else begin
      vsat = vreg_q;
    end
    vstep     = {7'h00, vsat} * `CDV_VREG_STEP_MV;        // [R8]
    vreg_mv_d = `CDV_VREG_BASE_MV + vstep;                // [R8]
  end

  // Outputs show hard defaults in reset, then the trim-loaded fields
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= `CDV_RDATA_UNMAPPED;
    end else begin
      reg_rdata_q <= reg_rdata_d;                         // [R1]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      reg_hit_q <= `CDV_RST_FLAG;
    end else begin
      reg_hit_q <= reg_hit_d;                             // [R1]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      dead_phase_timer_sel_q <= `CDV_RST_DEAD_TMR;
    end else begin
      dead_phase_timer_sel_q <= timer_sel_d;              // [R2]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      dead_phase_timer_sec_q <= `CDV_TMR_5S;
    end else begin
      dead_phase_timer_sec_q <= timer_sec_d;              // [R2]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      dead_phase_current_sel_q <= `CDV_RST_DEAD_CUR;
    end else begin
      dead_phase_current_sel_q <= cur_sel_d;              // [R3]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      dead_phase_current_ma_q <= `CDV_RST_DEAD_CUR;
    end else begin
      dead_phase_current_ma_q <= cur_ma_d;                // [R3]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      dead_current_over_precharge_q <= `CDV_RST_FLAG;
    end else begin
      dead_current_over_precharge_q <= over_d;            // [R4]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      recharge_sel_q <= `CDV_RST_RESTART;
    end else begin
      recharge_sel_q <= rchg_sel_d;                       // [R6]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      recharge_drop_mv_q <= `CDV_RESTART_LO_MV;
    end else begin
      recharge_drop_mv_q <= drop_mv_d;                    // [R6]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      vreg_code_q <= `CDV_RST_VREG;
    end else begin
      vreg_code_q <= vreg_code_d;                         // [R8]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      vreg_mv_q <= `CDV_RST_VREG_MV;
    end else begin
      vreg_mv_q <= vreg_mv_d;                             // [R9]
    end
  end

endmodule // cdv_regs

// file: design/cdv_regs_map.vh
// Purpose: Offsets, field positions, resets and decode limits for the
//          dead-battery and battery-voltage configuration registers.
// Assumes: 8-bit register bus with byte addresses.
// Notes:   Definitions only.
`ifndef CDV_REGS_MAP_VH
`define CDV_REGS_MAP_VH

`define CDV_ADDR_DEAD_CFG    8'h14
`define CDV_ADDR_VBAT_CFG    8'h15

`define CDV_DEAD_TMR_HI      7
`define CDV_DEAD_TMR_LO      6
`define CDV_DEAD_CUR_HI      5
`define CDV_DEAD_CUR_LO      0
`define CDV_DEAD_TRIM_B2     2
`define CDV_DEAD_TRIM_B4     4
`define CDV_RESERVED_BIT_BIT         7
`define CDV_RESTART_BIT      6
`define CDV_VREG_HI          5
`define CDV_VREG_LO          0

`define CDV_RST_DEAD_TMR     2'h0
`define CDV_RST_DEAD_CUR     6'h04
`define CDV_RST_RESERVED_BIT         1'h0
`define CDV_RST_RESTART      1'h0
`define CDV_RST_VREG         6'h1E
`define CDV_RST_PRECHG       6'h08
`define CDV_RST_VREG_MV      13'h1068
`define CDV_RST_FLAG         1'h0
`define CDV_RDATA_UNMAPPED   8'h00

`define CDV_VREG_MAX_CODE    6'h32
`define CDV_VREG_BASE_MV     13'h0E10
`define CDV_VREG_STEP_MV     13'h0014
`define CDV_RESTART_LO_MV    8'h8C
`define CDV_RESTART_HI_MV    8'hF0
`define CDV_TMR_5S           6'h05
`define CDV_TMR_10S          6'h0A
`define CDV_TMR_20S          6'h14
`define CDV_TMR_40S          6'h28

`endif

// file: test/cdv_host.sv
// Purpose: Host model making single-byte register accesses.
// Assumes: Strobe high one cycle, driven 2 ns after the edge.
// Notes:   Never asks for more dead current than pre-charge.
`timescale 1ns/1ps
module cdv_host (
  input  wire       clk,
  input  wire [5:0] precharge_current_sel,
  output reg  [7:0] reg_addr,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_wdata
);
  reg [7:0] sent;
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;
  task xfer(input w, input [7:0] a, input [7:0] d);
    @(posedge clk) #2;
    sent = (a == 8'h14 && d[5:0] > precharge_current_sel) ?
      {d[7:6], precharge_current_sel} : d;
    {reg_addr, reg_wr, reg_rd, reg_wdata} = {a, w, !w, sent};
    @(posedge clk) #2;
    // Released data must not look like a held value
    {reg_wr, reg_rd, reg_wdata} = {2'h0, ~sent};
  endtask
endmodule // cdv_host

// file: test/cdv_regs_assertions.sv
// Purpose: Port checks for the charger configuration registers.
// Assumes: Decoded outputs lag the stored fields by one cycle.
// Notes:   Bound into every register block instance.
`timescale 1ns/1ps
module cdv_regs_assertions (
  input wire        clk,
  input wire        rst_n,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata_q,
  input wire        reg_hit_q,
  input wire        charger_write_lock,
  input wire [1:0]  dead_phase_timer_sel_q,
  input wire [5:0]  dead_phase_timer_sec_q,
  input wire [5:0]  dead_phase_current_sel_q,
  input wire [5:0]  dead_phase_current_ma_q,
  input wire        recharge_sel_q,
  input wire [7:0]  recharge_drop_mv_q,
  input wire [5:0]  vreg_code_q,
  input wire [12:0] vreg_mv_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hit; reg_rd && reg_addr[7:1] == 7'h0A; endsequence
  sequence s_vwr; reg_wr && !charger_write_lock && reg_addr == 8'h15;
  endsequence
  property p_hit; s_hit |=> reg_hit_q; endproperty
  a_hit: assert property (p_hit) else $error("hit missing");
  property p_vwr; s_vwr |=> ##1
    {2'h0, vreg_code_q} == ($past(reg_wdata, 2) & 8'h3F); endproperty
  a_vwr: assert property (p_vwr) else $error("write lost");
  // First edge after reset still shows hard defaults, hence the guard
  property p_lock; reg_wr && charger_write_lock && $past(rst_n) |=> ##1
    $stable(vreg_code_q) && $stable(dead_phase_current_sel_q); endproperty
  a_lock: assert property (p_lock) else $error("locked write");
  property p_rd; reg_rd && reg_addr == 8'h15 && $past(rst_n) |=>
    reg_rdata_q[5:0] == vreg_code_q; endproperty
  a_rd: assert property (p_rd) else $error("read mismatch");
  property p_tmr;
    dead_phase_timer_sec_q == (6'h05 << dead_phase_timer_sel_q); endproperty
  a_tmr: assert property (p_tmr) else $error("timer decode");
  property p_cur;
    dead_phase_current_ma_q == dead_phase_current_sel_q; endproperty
  a_cur: assert property (p_cur) else $error("current decode");
  property p_drop;
    recharge_drop_mv_q == (recharge_sel_q ? 8'hF0 : 8'h8C); endproperty
  a_drop: assert property (p_drop) else $error("drop decode");
  property p_vmv; vreg_mv_q == 13'h0E10 + 13'h0014 *
    (vreg_code_q > 6'h32 ? 6'h32 : vreg_code_q); endproperty
  a_vmv: assert property (p_vmv) else $error("voltage decode");
endmodule // cdv_regs_assertions
bind cdv_regs cdv_regs_assertions chk (.*);

// file: test/cdv_regs_bench.sv
// Purpose: Self-checking bench for the charger config registers.
// Assumes: Host model drives the register strobes.
// Notes:   Mirror holds what the host actually wrote.
`timescale 1ns/1ps
module cdv_regs_bench;
  reg        clk = 0, rst_n = 0, charger_write_lock = 0;
  reg        trim_dead_b2 = 1, trim_dead_b4 = 0, trim_restart = 0;
  reg  [5:0] trim_vreg = 6'h1E, precharge_current_sel = 6'h08;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q, recharge_drop_mv_q;
  wire       reg_wr, reg_rd, reg_hit_q, recharge_sel_q;
  wire       dead_current_over_precharge_q;
  wire [1:0] dead_phase_timer_sel_q;
  wire [5:0] dead_phase_timer_sec_q, dead_phase_current_sel_q;
  wire [5:0] dead_phase_current_ma_q, vreg_code_q;
  wire [12:0] vreg_mv_q;
  reg  [7:0] m [0:1];
  reg  [7:0] a, d;
  integer    fails = 0, samples_checked = 0, i, cyc = 0;
  cdv_regs uut (.*);
  cdv_host h (.*);
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (++cyc > 2000) begin
    fails++;
    report_and_stop;
  end
  task cmp(input [15:0] g, input [15:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  function [12:0] vmv_f(input [5:0] c);
    vmv_f = 13'h0E10 + 13'h0014 * (c > 6'h32 ? 6'h32 : c);
  endfunction
  task chk_all;
    h.xfer(1'h0, 8'h14, 8'h00);
    cmp({reg_hit_q, reg_rdata_q}, {1'h1, m[0]});
    h.xfer(1'h0, 8'h15, 8'h00);
    cmp({reg_hit_q, reg_rdata_q}, {1'h1, m[1]});
    cmp(dead_phase_timer_sec_q, 6'h05 << m[0][7:6]);
    cmp(dead_phase_current_ma_q, m[0][5:0]);
    cmp(recharge_drop_mv_q, m[1][6] ? 8'hF0 : 8'h8C);
    cmp(vreg_mv_q, vmv_f(m[1][5:0]));
    cmp({dead_phase_timer_sel_q, dead_phase_current_sel_q}, m[0]);
    cmp({recharge_sel_q, vreg_code_q}, m[1][6:0]);
    cmp(dead_current_over_precharge_q,
      m[0][5:0] > precharge_current_sel);
    h.xfer(1'h0, 8'h16, 8'h00);
    cmp({reg_hit_q, reg_rdata_q}, 9'h000);
  endtask
  task do_reset;
    rst_n = 0;
    repeat (10) @(posedge clk);
    #2 rst_n = 1;
    m[0] = {3'h0, trim_dead_b4, 1'h0, trim_dead_b2, 2'h0};
    m[1] = {1'h0, trim_restart, trim_vreg};
    chk_all;
  endtask
  task report_and_stop;
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    d = $urandom(32'h0A42);
    do_reset;
    {trim_dead_b2, trim_dead_b4, trim_restart, trim_vreg} = $urandom;
    precharge_current_sel = 6'h20 + $urandom % 32;
    do_reset;
    for (i = 0; i < 40; i++) begin
      // Saturation corners first, then random traffic
      a = i < 4 ? 8'h15 : 8'h14 + $urandom % 3;
      d = i < 4 ? (i == 3 ? 8'h3F : 8'hF1 + i) : $urandom;
      charger_write_lock = i > 3 && $urandom % 4 == 0;
      h.xfer(1'h1, a, d);
      cmp(reg_hit_q, a != 8'h16);
      if (!charger_write_lock && a != 8'h16) m[a[0]] = h.sent;
      chk_all;
    end
    // Pre-charge drops below the stored code: the flag must show it
    charger_write_lock = 0;
    precharge_current_sel = 6'h3F;
    h.xfer(1'h1, 8'h14, 8'h2A);
    m[0] = h.sent;
    precharge_current_sel = 6'h01;
    chk_all;
    report_and_stop;
  end
endmodule // cdv_regs_bench
